// >>> hw/relative_branch_exec.sv
// Contract
// - opcode E7xx branches to pc+2+2n when negative flag is clear
// - opcode E5xx branches to pc+2+2n when overflow flag is clear
// - opcode E1xx branches to pc+2+2n when zero flag is clear
// - top bits 11010 always branch, 11-bit signed offset -1024..1023
// - conditional offset is low eight bits, signed -128..127
// - offset is two's complement, doubled, added to incremented pc
// - conditional takes one cycle untaken, two taken, second cycle idle
// - unconditional takes two cycles, pc written in Q4 of first
`timescale 1ns/1ps
`default_nettype none

module relative_branch_exec #(
  parameter int PC_W = branch_pkg::PC_W_DEF
) (
  // clock and reset
  input  wire logic            ref_clk_in,
  input  wire logic            reset_n_in,
  // instruction register, held through Q1
  input  wire logic            instr_valid_in,
  input  wire logic [15:0]     instr_word_in,
  // already incremented program counter
  input  wire logic [PC_W-1:0] pc_in,
  // alu status flags
  input  wire logic            negative_in,
  input  wire logic            overflow_in,
  input  wire logic            zero_in,
  // program counter load
  output logic                 pc_load_out,
  output logic [PC_W-1:0]      pc_target_out,
  // sequencing
  output logic [1:0]           quarter_out,
  output logic                 busy_out,
  output logic                 dead_cycle_out
);
  import branch_pkg::*;

  typedef struct packed {
    logic [1:0]      phase;
    exec_state_t     st;
    br_kind_t        kind;
    logic            taken;
    logic [PC_W-1:0] target;
    logic            pc_load;
  } state_t;

  state_t          q;
  state_t          d;
  br_kind_t        kind;
  logic            cond_met;
  logic [PC_W-1:0] offset;
  logic            capture;

  // decode only; this block has no path to the status flags
  always_comb begin
    kind = BK_NONE;
    if (instr_word_in[15:8] == OPC_NOT_NEG) begin
      kind = BK_NOT_NEG;
    end else if (instr_word_in[15:8] == OPC_NO_OVF) begin
      kind = BK_NO_OVF;
    end else if (instr_word_in[15:8] == OPC_NONZERO) begin
      kind = BK_NONZERO;
    end else if (instr_word_in[15:11] == OPC_ALWAYS) begin
      kind = BK_ALWAYS;
    end
  end

  always_comb begin
    cond_met = 1'b0;
    unique case (kind)
      BK_NOT_NEG: cond_met = !negative_in;
      BK_NO_OVF:  cond_met = !overflow_in;
      BK_NONZERO: cond_met = !zero_in;
      BK_ALWAYS:  cond_met = 1'b1;
      BK_NONE:    cond_met = 1'b0;
    endcase
  end

  // sign-extend and double; pc_in already points past this word
  always_comb begin
    if (kind == BK_ALWAYS) begin
      offset = {{(PC_W-LONG_OFS_W-1){instr_word_in[LONG_OFS_W-1]}},
                instr_word_in[LONG_OFS_W-1:0], 1'b0};
    end else begin
      offset = {{(PC_W-SHORT_OFS_W-1){instr_word_in[SHORT_OFS_W-1]}},
                instr_word_in[SHORT_OFS_W-1:0], 1'b0};
    end
  end

  // instructions offered during the dead cycle are flushed, not decoded
  assign capture = (q.st == ST_RUN) && (q.phase == PHASE_Q1) && instr_valid_in
                   && (kind != BK_NONE);

  always_comb begin
    d         = q;
    d.phase   = q.phase + 2'h1;
    d.pc_load = 1'b0;
    unique case (q.st)
      ST_RUN: begin
        if (capture) begin
          d.st     = ST_EXEC;
          d.kind   = kind;
          d.taken  = cond_met;
          d.target = pc_in + offset;
        end
      end
      ST_EXEC: begin
        // load is raised so that it stands through Q4 only
        if (q.phase == PHASE_Q3) begin
          d.pc_load = q.taken;
        end
        if (q.phase == PHASE_Q4) begin
          d.st = q.taken ? ST_DEAD : ST_RUN;
        end
      end
      ST_DEAD: begin
        if (q.phase == PHASE_Q4) begin
          d.st = ST_RUN;
        end
      end
      default: d.st = ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '{phase: PHASE_Q1, st: ST_RUN, kind: BK_NONE, taken: 1'b0,
             target: '0, pc_load: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign pc_load_out    = q.pc_load;
  assign pc_target_out  = q.target;
  assign quarter_out    = q.phase;
  assign busy_out       = (q.st != ST_RUN);
  assign dead_cycle_out = (q.st == ST_DEAD);

  // reference target built a second way, by signed arithmetic
  logic [PC_W-1:0] ref_short;
  logic [PC_W-1:0] ref_long;
  assign ref_short = PC_W'($signed({1'b0, pc_in})
                     + (PC_W+1)'($signed(instr_word_in[SHORT_OFS_W-1:0]) * 2));
  assign ref_long  = PC_W'($signed({1'b0, pc_in})
                     + (PC_W+1)'($signed(instr_word_in[LONG_OFS_W-1:0]) * 2));

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_taken_tail;
    pc_load_out ##1 dead_cycle_out [*4] ##1 !dead_cycle_out;
  endsequence

  sequence s_untaken_tail;
    !pc_load_out ##1 !dead_cycle_out && !busy_out;
  endsequence

  property p_not_neg;
    capture && (instr_word_in[15:8] == OPC_NOT_NEG) |->
      ##3 (pc_load_out == !$past(negative_in, 3));
  endproperty
  a_not_neg: assert property (p_not_neg) else $error("negative branch decision wrong");

  property p_no_ovf;
    capture && (instr_word_in[15:8] == OPC_NO_OVF) && !overflow_in |-> ##3 s_taken_tail;
  endproperty
  a_no_ovf: assert property (p_no_ovf) else $error("overflow branch not taken");

  property p_nonzero;
    capture && (instr_word_in[15:8] == OPC_NONZERO) |->
      ##3 (pc_load_out == !$past(zero_in, 3));
  endproperty
  a_nonzero: assert property (p_nonzero) else $error("zero branch decision wrong");

  property p_long_target;
    capture && (instr_word_in[15:11] == OPC_ALWAYS) |->
      ##3 pc_load_out && (pc_target_out == $past(ref_long, 3));
  endproperty
  a_long_target: assert property (p_long_target) else $error("always target wrong");

  property p_short_target;
    capture && (kind != BK_ALWAYS) && cond_met |->
      ##3 pc_target_out == $past(ref_short, 3);
  endproperty
  a_short_target: assert property (p_short_target) else $error("short target wrong");

  property p_untaken;
    capture && !cond_met |-> ##3 s_untaken_tail;
  endproperty
  a_untaken: assert property (p_untaken) else $error("untaken branch stalled");

  property p_always_two;
    capture && (kind == BK_ALWAYS) |-> ##3 s_taken_tail;
  endproperty
  a_always_two: assert property (p_always_two) else $error("always branch not two cycles");

  property p_load_in_q4;
    pc_load_out |-> (quarter_out == PHASE_Q4) && !dead_cycle_out;
  endproperty
  a_load_in_q4: assert property (p_load_in_q4) else $error("pc load outside Q4");

  property p_one_word;
    capture |=> busy_out [*3] ##1 (dead_cycle_out || !busy_out);
  endproperty
  a_one_word: assert property (p_one_word) else $error("branch spans wrong length");

  // unconditional form must never reach the untaken path
  property p_always_taken;
    (q.st == ST_EXEC) && (q.kind == BK_ALWAYS) |-> q.taken;
  endproperty
  a_always_taken: assert property (p_always_taken) else $error("always untaken");

  property p_refused;
    (q.st == ST_RUN) && (q.phase == PHASE_Q1) && (kind == BK_NONE) |=> !busy_out;
  endproperty
  a_refused: assert property (p_refused) else $error("non-branch word captured");

endmodule

`default_nettype wire

// >>> hw/branch_pkg.sv
package branch_pkg;
  // upper byte patterns of the conditional forms
  localparam logic [7:0] OPC_NOT_NEG  = 8'hE7;
  localparam logic [7:0] OPC_NO_OVF   = 8'hE5;
  localparam logic [7:0] OPC_NONZERO  = 8'hE1;
  // top five bits of the unconditional form
  localparam logic [4:0] OPC_ALWAYS   = 5'h1A;
  // offset field widths
  localparam int         SHORT_OFS_W  = 8;
  localparam int         LONG_OFS_W   = 11;
  // quarter phases of one instruction cycle
  localparam logic [1:0] PHASE_Q1     = 2'h0;
  localparam logic [1:0] PHASE_Q2     = 2'h1;
  localparam logic [1:0] PHASE_Q3     = 2'h2;
  localparam logic [1:0] PHASE_Q4     = 2'h3;
  localparam int         PC_W_DEF     = 21;

  typedef enum logic [2:0] {
    BK_NONE,
    BK_NOT_NEG,
    BK_NO_OVF,
    BK_NONZERO,
    BK_ALWAYS
  } br_kind_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_EXEC,
    ST_DEAD
  } exec_state_t;
endpackage

// >>> testbench/relative_branch_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none

module relative_branch_exec_bench;
  import branch_pkg::*;
  logic                ref_clk_in;
  logic                reset_n_in;
  logic                instr_valid_in;
  logic [15:0]         instr_word_in;
  logic [PC_W_DEF-1:0] pc_in;
  logic                negative_in;
  logic                overflow_in;
  logic                zero_in;
  logic                pc_load_out;
  logic [PC_W_DEF-1:0] pc_target_out;
  logic [1:0]          quarter_out;
  logic                busy_out;
  logic                dead_cycle_out;
  int                  errors;
  int                  checks_done;

  relative_branch_exec u_relative_branch_exec (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .instr_valid_in(instr_valid_in),
    .instr_word_in(instr_word_in), .pc_in(pc_in), .negative_in(negative_in),
    .overflow_in(overflow_in), .zero_in(zero_in), .pc_load_out(pc_load_out),
    .pc_target_out(pc_target_out), .quarter_out(quarter_out), .busy_out(busy_out),
    .dead_cycle_out(dead_cycle_out));

  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic results();
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // flags and pc flipped after capture: catches late sampling
  task automatic exec(input logic [15:0] w, input logic [2:0] nvz, input logic [20:0] pc,
                      input logic dec, input logic tk, input int ofs);
    logic [20:0] tgt;
    tgt = pc + 21'(2 * ofs);
    @(posedge ref_clk_in);
    instr_word_in <= w;
    {negative_in, overflow_in, zero_in} <= nvz;
    pc_in <= pc;
    instr_valid_in <= 1'b1;
    // look once the edge has settled; idle Q1 means the next edge captures
    #1;
    while (!(quarter_out === 2'h0 && busy_out === 1'b0)) begin
      @(posedge ref_clk_in);
      #1;
    end
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b0;
    {negative_in, overflow_in, zero_in} <= ~nvz;
    pc_in <= ~pc;
    for (int i = 1; i <= 8; i++) begin
      #1;
      check(quarter_out, i % 4, "quarter");
      check(pc_load_out, (i == 3) && tk, "pc load");
      check(busy_out, (i < 4) ? dec : (tk && i < 8), "busy");
      check(dead_cycle_out, tk && i >= 4 && i < 8, "dead cycle");
      if (i == 3 && tk) check(pc_target_out, tgt, "target");
      @(posedge ref_clk_in);
    end
  endtask

  // reset in the middle of a taken branch, then the phase restarts
  task automatic test_reset_mid();
    @(posedge ref_clk_in);
    instr_word_in <= 16'hD001;
    instr_valid_in <= 1'b1;
    #1;
    while (!(quarter_out === 2'h0 && busy_out === 1'b0)) begin
      @(posedge ref_clk_in);
      #1;
    end
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b0;
    #1;
    check(busy_out, 1'b1, "busy before reset");
    @(posedge ref_clk_in);
    reset_n_in <= 1'b0;
    #1;
    check({pc_load_out, busy_out, dead_cycle_out, quarter_out}, 5'h00, "reset outputs");
    check(pc_target_out, 21'h000000, "reset target");
    repeat (2) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    #1;
    check(quarter_out, 2'h0, "quarter at release");
    @(posedge ref_clk_in);
    #1;
    check(quarter_out, 2'h1, "quarter after release");
    check(busy_out, 1'b0, "idle after release");
  endtask

  task automatic test_not_neg();
    exec(16'hE77F, 3'b011, 21'h001000, 1'b1, 1'b1, 127);
    exec(16'hE780, 3'b100, 21'h001000, 1'b1, 1'b0, -128);
  endtask

  task automatic test_no_ovf();
    exec(16'hE580, 3'b101, 21'h000200, 1'b1, 1'b1, -128);
    exec(16'hE501, 3'b010, 21'h000200, 1'b1, 1'b0, 1);
  endtask

  task automatic test_nonzero();
    exec(16'hE1FF, 3'b110, 21'h000010, 1'b1, 1'b1, -1);
    exec(16'hE17F, 3'b001, 21'h000010, 1'b1, 1'b0, 127);
  endtask

  task automatic test_always();
    exec(16'hD3FF, 3'b111, 21'h000400, 1'b1, 1'b1, 1023);
    // negative offset from zero wraps the target
    exec(16'hD400, 3'b111, 21'h000000, 1'b1, 1'b1, -1024);
  endtask

  task automatic test_refused();
    exec(16'hE600, 3'b000, 21'h000100, 1'b0, 1'b0, 0);
    exec(16'hD800, 3'b000, 21'h000100, 1'b0, 1'b0, 0);
  endtask

  initial begin
    errors = 0;
    checks_done = 0;
    reset_n_in = 1'b0;
    instr_valid_in = 1'b0;
    instr_word_in = 16'h0000;
    pc_in = 21'h000000;
    negative_in = 1'b0;
    overflow_in = 1'b0;
    zero_in = 1'b0;
    repeat (16) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    test_not_neg();
    test_no_ovf();
    test_nonzero();
    test_always();
    test_reset_mid();
    test_refused();
    results();
  end

  // about 150 cycles expected; generous margin
  initial begin
    #200000;
    errors++;
    results();
  end
endmodule

`default_nettype wire
